// >>> dmac_pkg.sv
// Shared constants and types of the multiply-accumulate macro.
package dmac_pkg;
	localparam int OP_W   = 18;
	localparam int C_W    = 54;
	localparam int CAS_W  = 55;
	localparam int OUT_W  = 36;
	localparam int LP_W   = 40;
	localparam int NGRP   = 4;
	// Register groups, each with its own enable and reset.
	localparam int GRP_IN   = 0;
	localparam int GRP_MIN  = 1;
	localparam int GRP_MOUT = 2;
	localparam int GRP_OUT  = 3;
	// Mode register layout.
	localparam int OPM_W       = 6;
	localparam int OPM_MUL_LSB = 0;
	localparam int OPM_ALU_LSB = 2;
	localparam int OPM_SUB_BIT = 4;
	localparam int OPM_ZERO    = 5;
	localparam logic [5:0] OPM_RESET = 6'h00;
	localparam logic [17:0] OP_RESET = 18'h00000;
	typedef enum logic [1:0] {
		MUL_18    = 2'b00,
		MUL_9     = 2'b01,
		MUL_18X36 = 2'b10,
		MUL_36    = 2'b11
	} dmac_mul_t;
	typedef enum logic [1:0] {
		ALU_AB  = 2'b00,
		ALU_BC  = 2'b01,
		ALU_ABC = 2'b10,
		ALU_CAS = 2'b11
	} dmac_alu_t;
endpackage

// >>> dmac_skid.sv
// Two-entry result buffer with registered ready and registered output.
`timescale 1ns/1ps
`default_nettype none
module dmac_skid #(
	parameter int W = 36
) (
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic         i_ce,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic [W-1:0]      o_data
);
	logic [W-1:0] skid_r;
	logic         ready_r;
	logic         valid_r;
	logic [W-1:0] data_r;

	assign o_ready = ready_r;
	assign o_valid = valid_r;
	assign o_data  = data_r;

	// The second entry only fills when the receiver stalls a held word.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ready_r <= 1'b1;
			valid_r <= 1'b0;
			data_r  <= '0;
			skid_r  <= '0;
		end else if (i_ce) begin
			if (ready_r) begin
				if (valid_r && !i_ready) begin
					if (i_valid) begin
						skid_r  <= i_data;
						ready_r <= 1'b0;
					end
				end else begin
					valid_r <= i_valid;
					data_r  <= i_data;
				end
			end else if (i_ready) begin
				data_r  <= skid_r;
				valid_r <= 1'b1;
				ready_r <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dmac_macro.sv
// Multiply-accumulate macro: pre-adders, multipliers, wide ALU, chains.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Shift chain A output repeats its input one clock later.
// - Shift chain B output repeats its input one clock later.
// - Cascade output is 55 bits, top bit sign-extends the ALU result.
// - Cascade input from the previous block is an ALU operand.
// - Two pre-adders, two 18x18 multipliers and one three-input ALU.
// - Pre-adder takes B or backward shift, and A or forward shift.
// - Two-bit control picks add or subtract for each pre-adder.
// - Pre-adder inputs are registered or bypassed by configuration.
// - Pre-adder works standalone at 9-bit or 18-bit width.
// - Multipliers form one 18x36, two 18x18 or four 9x9 products.
// - Two adjacent macros combine into one 36x36 multiplier.
// - Multiplier inputs and outputs are registered or bypassed.
// - 54-bit ALU with registered or bypassed inputs and outputs.
// - ALU adds or subtracts A and B onto product or zero.
// - ALU adds or subtracts B and C onto product or zero.
// - ALU combines A, B and C without the product.
// - Per-operand sign controls make A and B signed or unsigned.
// - Two-bit selects choose sources of multiplier A and B operands.
// - Four enables and four clocked resets, each gated by its enable or not.
// - Operation mode is held in its own internal register.
module dmac_macro (
	// Clock, reset and global freeze
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	input  wire logic        I_CE,
	// Register group enables, resets and reset style
	input  wire logic [3:0]  I_CE_GRP,
	input  wire logic [3:0]  I_RESET_GRP,
	input  wire logic [3:0]  I_RST_ASYNC,
	// Configuration
	input  wire logic [3:0]  I_REG_EN,
	input  wire logic [1:0]  I_PREADD_EN,
	input  wire logic        I_PREADD_W9,
	input  wire logic [5:0]  I_OPERATION_MODE_CONTROL,
	// Operand controls
	input  wire logic [1:0]  I_PREADD_SUB_SELECT,
	input  wire logic [1:0]  I_OPERAND_A_SOURCE_SELECT,
	input  wire logic [1:0]  I_OPERAND_B_SOURCE_SELECT,
	input  wire logic [1:0]  I_OPERAND_A_SIGNED,
	input  wire logic [1:0]  I_OPERAND_B_SIGNED,
	// Operand data
	input  wire logic        I_VALID,
	input  wire logic [17:0] I_A0,
	input  wire logic [17:0] I_A1,
	input  wire logic [17:0] I_B0,
	input  wire logic [17:0] I_B1,
	input  wire logic [53:0] I_C,
	// Chains from the neighbours
	input  wire logic [17:0] I_SHIFT_IN_A,
	input  wire logic [17:0] I_SHIFT_IN_B,
	input  wire logic [17:0] I_PREADD_BACK_SHIFT_IN,
	input  wire logic [54:0] I_CASCADE_IN,
	// Chains to the neighbours
	output logic [17:0]      O_SHIFT_OUT_A,
	output logic [17:0]      O_SHIFT_OUT_B,
	output logic [17:0]      O_PREADD_BACK_SHIFT_OUT,
	output logic [54:0]      O_CASCADE_OUT,
	// Result stream
	output logic             O_READY,
	output logic             O_VALID,
	input  wire logic        I_READY,
	output logic [35:0]      O_DOUT
);
	localparam int BW = 2 * dmac_pkg::OUT_W + dmac_pkg::C_W;

	logic              buf_rdy;
	logic              adv;
	logic [3:0]        en_g;
	logic [3:0]        clr_g;
	logic [17:0]       a_in [2];
	logic [17:0]       b_in [2];
	logic [17:0]       a_r [2];
	logic [17:0]       b_r [2];
	logic [17:0]       a_s [2];
	logic [17:0]       b_s [2];
	logic signed [19:0] pre_adder [2];
	logic signed [19:0] pa_r [2];
	logic signed [19:0] pa_s [2];
	logic signed [18:0] pb_r [2];
	logic signed [18:0] pb_s [2];
	logic signed [39:0] m_lane [2];
	logic signed [39:0] pm_r [2];
	logic signed [39:0] pm_s [2];
	logic [53:0]       c_r;
	logic [BW-1:0]     ops0;
	logic [BW-1:0]     ops1_r;
	logic [BW-1:0]     ops1_s;
	logic [BW-1:0]     ops2_r;
	logic [BW-1:0]     ops2_s;
	logic [3:0]        v_r;
	logic [3:0]        v_s;
	logic [5:0]        opm_r;
	logic signed [53:0] prod;
	logic signed [53:0] t0;
	logic signed [53:0] aa;
	logic signed [53:0] bb;
	logic signed [53:0] cc;
	logic signed [53:0] cas;
	logic signed [53:0] alu_res;
	logic [53:0]       res_r;
	logic [53:0]       res_s;
	logic [17:0]       sha_r;
	logic [17:0]       shb_r;
	logic [17:0]       bsh_r;
	logic [54:0]       cas_r;
	dmac_pkg::dmac_mul_t mul_mode;
	dmac_pkg::dmac_alu_t alu_fn;
	logic              alu_sub;

	// Everything stalls together when the buffer cannot take a word.
	assign adv = I_CE & buf_rdy;
	always_comb begin
		for (int g = 0; g < dmac_pkg::NGRP; g++) begin
			en_g[g] = adv & I_CE_GRP[g];
			// An asynchronous-style reset ignores its group enable.
			clr_g[g] = I_CE & I_RESET_GRP[g]
				& (I_RST_ASYNC[g] | en_g[g]);
		end
	end

	assign a_in[0] = I_A0;
	assign a_in[1] = I_A1;
	assign b_in[0] = I_B0;
	assign b_in[1] = I_B1;

	// Mode register loads apart from the data path.
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN)
			opm_r <= dmac_pkg::OPM_RESET;
		else if (clr_g[dmac_pkg::GRP_OUT])
			opm_r <= dmac_pkg::OPM_RESET;
		else if (en_g[dmac_pkg::GRP_OUT])
			opm_r <= I_OPERATION_MODE_CONTROL;
	end
	assign mul_mode = dmac_pkg::dmac_mul_t'(opm_r[1:0]);
	assign alu_fn   = dmac_pkg::dmac_alu_t'(opm_r[3:2]);
	assign alu_sub  = opm_r[dmac_pkg::OPM_SUB_BIT];

	// Chain registers and the C register share the input group.
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sha_r <= dmac_pkg::OP_RESET;
			shb_r <= dmac_pkg::OP_RESET;
			bsh_r <= dmac_pkg::OP_RESET;
			c_r   <= '0;
		end else if (clr_g[dmac_pkg::GRP_IN]) begin
			sha_r <= dmac_pkg::OP_RESET;
			shb_r <= dmac_pkg::OP_RESET;
			bsh_r <= dmac_pkg::OP_RESET;
			c_r   <= '0;
		end else if (en_g[dmac_pkg::GRP_IN]) begin
			sha_r <= I_SHIFT_IN_A;
			shb_r <= I_SHIFT_IN_B;
			bsh_r <= b_s[0];
			c_r   <= I_C;
		end
	end

	// Two identical lanes: pre-adder and one multiplier each.
	for (genvar i = 0; i < 2; i++) begin : g_lane
		logic [17:0]        a_src;
		logic [17:0]        b_src;
		logic signed [19:0] ea;
		logic signed [19:0] eb;
		logic signed [9:0]  lo;
		logic signed [9:0]  hi;
		logic signed [19:0] p_lo;
		logic signed [19:0] p_hi;
		logic               sa;
		logic               sb;

		assign sa = I_OPERAND_A_SIGNED[i];
		assign sb = I_OPERAND_B_SIGNED[i];
		assign a_src = I_OPERAND_A_SOURCE_SELECT[i] ?
			I_SHIFT_IN_A : a_in[i];
		assign b_src = I_OPERAND_B_SOURCE_SELECT[i] ?
			I_PREADD_BACK_SHIFT_IN : b_in[i];

		always_ff @(posedge I_CLK or negedge I_RSTN) begin
			if (!I_RSTN) begin
				a_r[i] <= dmac_pkg::OP_RESET;
				b_r[i] <= dmac_pkg::OP_RESET;
			end else if (clr_g[dmac_pkg::GRP_IN]) begin
				a_r[i] <= dmac_pkg::OP_RESET;
				b_r[i] <= dmac_pkg::OP_RESET;
			end else if (en_g[dmac_pkg::GRP_IN]) begin
				a_r[i] <= a_src;
				b_r[i] <= b_src;
			end
		end
		assign a_s[i] = I_REG_EN[0] ? a_r[i] : a_src;
		assign b_s[i] = I_REG_EN[0] ? b_r[i] : b_src;

		// Narrow mode takes bit 8 as the top of each operand.
		always_comb begin
			if (I_PREADD_W9) begin
				ea = {{11{sa & a_s[i][8]}}, a_s[i][8:0]};
				eb = {{11{sb & b_s[i][8]}}, b_s[i][8:0]};
			end else begin
				ea = {{2{sa & a_s[i][17]}}, a_s[i]};
				eb = {{2{sb & b_s[i][17]}}, b_s[i]};
			end
		end
		assign pre_adder[i] = I_PREADD_SUB_SELECT[i] ? ea - eb : ea + eb;

		always_ff @(posedge I_CLK or negedge I_RSTN) begin
			if (!I_RSTN) begin
				pa_r[i] <= '0;
				pb_r[i] <= '0;
			end else if (clr_g[dmac_pkg::GRP_MIN]) begin
				pa_r[i] <= '0;
				pb_r[i] <= '0;
			end else if (en_g[dmac_pkg::GRP_MIN]) begin
				pa_r[i] <= I_PREADD_EN[i] ? pre_adder[i] : ea;
				pb_r[i] <= eb[18:0];
			end
		end
		assign pa_s[i] = I_REG_EN[1] ? pa_r[i]
			: (I_PREADD_EN[i] ? pre_adder[i] : ea);
		assign pb_s[i] = I_REG_EN[1] ? pb_r[i] : eb[18:0];

		// Each lane splits into two 9x9 products in the narrow mode.
		// Fields are 19 bits so an unsigned product keeps its top bit.
		assign lo = {sa & pa_s[i][8], pa_s[i][8:0]};
		assign hi = {sb & pb_s[i][8], pb_s[i][8:0]};
		assign p_lo = lo * hi;
		assign p_hi = $signed({sa & pa_s[i][17], pa_s[i][17:9]})
			* $signed({sb & pb_s[i][17], pb_s[i][17:9]});
		assign m_lane[i] = (mul_mode == dmac_pkg::MUL_9) ?
			{2'h0, p_hi[18:0], p_lo[18:0]} : 40'(pa_s[i] * pb_s[i]);

		always_ff @(posedge I_CLK or negedge I_RSTN) begin
			if (!I_RSTN)
				pm_r[i] <= '0;
			else if (clr_g[dmac_pkg::GRP_MOUT])
				pm_r[i] <= '0;
			else if (en_g[dmac_pkg::GRP_MOUT])
				pm_r[i] <= m_lane[i];
		end
		assign pm_s[i] = I_REG_EN[2] ? pm_r[i] : m_lane[i];
	end

	// ALU operands follow the products through the same stages.
	assign ops0 = {I_C, a_s[1], a_s[0], b_s[1], b_s[0]};
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN)
			ops1_r <= '0;
		else if (clr_g[dmac_pkg::GRP_MIN])
			ops1_r <= '0;
		else if (en_g[dmac_pkg::GRP_MIN])
			ops1_r <= {I_REG_EN[0] ? c_r : I_C, ops0[71:0]};
	end
	assign ops1_s = I_REG_EN[1] ? ops1_r
		: {I_REG_EN[0] ? c_r : I_C, ops0[71:0]};
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN)
			ops2_r <= '0;
		else if (clr_g[dmac_pkg::GRP_MOUT])
			ops2_r <= '0;
		else if (en_g[dmac_pkg::GRP_MOUT])
			ops2_r <= ops1_s;
	end
	assign ops2_s = I_REG_EN[2] ? ops2_r : ops1_s;

	// Product combining per multiplier grouping.
	always_comb begin
		logic signed [53:0] w0;
		logic signed [53:0] w1;
		w0 = 54'(pm_s[0]);
		w1 = 54'(pm_s[1]);
		cas = I_CASCADE_IN[53:0];
		case (mul_mode)
			dmac_pkg::MUL_9:
				prod = 54'($signed(pm_s[0][18:0]) + $signed(pm_s[0][37:19])
					+ $signed(pm_s[1][18:0]) + $signed(pm_s[1][37:19]));
			dmac_pkg::MUL_18X36:
				prod = w0 + (w1 <<< 18);
			dmac_pkg::MUL_36:
				prod = ((w0 + (w1 <<< 18)) <<< 18) + cas;
			default:
				prod = w0 + w1;
		endcase
	end

	always_comb begin
		aa = {{18{I_OPERAND_A_SIGNED[1] & ops2_s[71]}}, ops2_s[71:36]};
		bb = {{18{I_OPERAND_B_SIGNED[1] & ops2_s[35]}}, ops2_s[35:0]};
		cc = ops2_s[125:72];
		t0 = opm_r[dmac_pkg::OPM_ZERO] ? 54'sh0 : prod;
		case (alu_fn)
			dmac_pkg::ALU_AB:
				alu_res = alu_sub ? t0 + aa - bb : t0 + aa + bb;
			dmac_pkg::ALU_BC:
				alu_res = alu_sub ? t0 + bb - cc : t0 + bb + cc;
			dmac_pkg::ALU_ABC:
				alu_res = alu_sub ? aa + bb - cc : aa + bb + cc;
			default:
				alu_res = alu_sub ? t0 - cas : t0 + cas;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			res_r <= '0;
			cas_r <= '0;
		end else if (clr_g[dmac_pkg::GRP_OUT]) begin
			res_r <= '0;
			cas_r <= '0;
		end else if (en_g[dmac_pkg::GRP_OUT]) begin
			res_r <= alu_res;
			cas_r <= {res_s[53], res_s};
		end
	end
	assign res_s = I_REG_EN[3] ? res_r : alu_res;

	// Valid markers ride with the stall only, so each word is sent once.
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN)
			v_r <= 4'h0;
		else if (adv)
			v_r <= {v_s[2:0], I_VALID} & ~clr_g;
	end
	always_comb begin
		v_s[0] = I_REG_EN[0] ? v_r[0] : I_VALID;
		for (int k = 1; k < 4; k++)
			v_s[k] = I_REG_EN[k] ? v_r[k] : v_s[k-1];
	end

	dmac_skid #(
		.W(dmac_pkg::OUT_W)
	) u_buf (
		.i_clk   (I_CLK),
		.i_rstn  (I_RSTN),
		.i_ce    (I_CE),
		.i_valid (v_s[3]),
		.o_ready (buf_rdy),
		.i_data  (res_s[35:0]),
		.o_valid (O_VALID),
		.i_ready (I_READY),
		.o_data  (O_DOUT)
	);

	assign O_READY                 = buf_rdy;
	assign O_SHIFT_OUT_A           = sha_r;
	assign O_SHIFT_OUT_B           = shb_r;
	assign O_PREADD_BACK_SHIFT_OUT = bsh_r;
	assign O_CASCADE_OUT           = cas_r;

	property p_shift_a;
		@(posedge I_CLK) disable iff (!I_RSTN)
		(en_g[0] && !clr_g[0]) |=> O_SHIFT_OUT_A == $past(I_SHIFT_IN_A);
	endproperty
	a_shift_a: assert property (p_shift_a)
		else $error("shift chain A latency wrong");
	property p_shift_b;
		@(posedge I_CLK) disable iff (!I_RSTN)
		(en_g[0] && !clr_g[0]) |=> O_SHIFT_OUT_B == $past(I_SHIFT_IN_B);
	endproperty
	a_shift_b: assert property (p_shift_b)
		else $error("shift chain B latency wrong");
	property p_cas_sign;
		@(posedge I_CLK) disable iff (!I_RSTN)
		O_CASCADE_OUT[54] == O_CASCADE_OUT[53];
	endproperty
	a_cas_sign: assert property (p_cas_sign)
		else $error("cascade top bit not sign extended");
	property p_cas_in;
		@(posedge I_CLK) disable iff (!I_RSTN)
		(alu_fn == dmac_pkg::ALU_CAS && !alu_sub
			&& opm_r[dmac_pkg::OPM_ZERO])
			|-> alu_res == $signed(I_CASCADE_IN[53:0]);
	endproperty
	a_cas_in: assert property (p_cas_in)
		else $error("cascade input not summed");
	property p_async_clr;
		@(posedge I_CLK) disable iff (!I_RSTN)
		(I_CE && I_RESET_GRP[3] && I_RST_ASYNC[3])
			|=> res_r == '0 && opm_r == dmac_pkg::OPM_RESET;
	endproperty
	a_async_clr: assert property (p_async_clr)
		else $error("group reset did not clear");
	property p_opm_load;
		@(posedge I_CLK) disable iff (!I_RSTN)
		(en_g[3] && !clr_g[3])
			|=> opm_r == $past(I_OPERATION_MODE_CONTROL);
	endproperty
	a_opm_load: assert property (p_opm_load)
		else $error("mode register not loaded");
	property p_hold;
		@(posedge I_CLK) disable iff (!I_RSTN)
		(!en_g[1] && !clr_g[1]) |=> $stable(pa_r[0]) && $stable(pb_r[1]);
	endproperty
	a_hold: assert property (p_hold)
		else $error("disabled register changed");
	property p_out_hold;
		@(posedge I_CLK) disable iff (!I_RSTN)
		(I_CE && O_VALID && !I_READY) |=> O_VALID && $stable(O_DOUT);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("stalled result lost");
	property p_bypass;
		@(posedge I_CLK) disable iff (!I_RSTN)
		(I_REG_EN == 4'h0 && adv && I_VALID && (!O_VALID || I_READY))
			|=> O_VALID && O_DOUT == $past(alu_res[35:0]);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass path latency wrong");

	c_stall: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
		!buf_rdy ##1 buf_rdy);
	c_mul36: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
		mul_mode == dmac_pkg::MUL_36 && O_VALID);
	c_piped: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_REG_EN == 4'hf && v_r[3]);
endmodule
`default_nettype wire

// >>> dmac_nbr_model.sv
// Neighbour model: chain word sources and a stalling result sink.
`timescale 1ns/1ps
`default_nettype none
module dmac_nbr_model (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// Behaviour controls
	input  wire logic        i_stall,
	input  wire logic        i_block,
	// Chain words and sink acceptance
	output logic [17:0]      o_sa,
	output logic [17:0]      o_sb,
	output logic [17:0]      o_bk,
	output logic [54:0]      o_cas,
	output logic             o_ready
);
	initial {o_sa, o_sb, o_bk, o_cas, o_ready} = '0;
	// Fresh words every cycle, so a register that fails to load shows up.
	always @(negedge i_clk) begin
		o_sa <= 18'($urandom);
		o_sb <= 18'($urandom);
		o_bk <= 18'($urandom);
		o_cas <= {23'($urandom), 32'($urandom)};
		o_ready <= i_rstn && !i_block && !(i_stall && $urandom_range(2) == 0);
	end
endmodule
`default_nettype wire

// >>> dmac_macro_tb.sv
// Self-checking bench of the multiply-accumulate macro.
`timescale 1ns/1ps
`default_nettype none
module dmac_macro_tb;
	logic        clk, rstn, ce, valid, blk, stall, rdy, o_ready, o_valid;
	logic        cas_p, sh_p, w9, bs_p;
	logic [17:0] bso, bs_l;
	logic [3:0]  ce_grp, rst_grp, rst_as, reg_en;
	logic [5:0]  opm;
	logic [1:0]  pen, psub, asel, operand_b_source_select, asg, bsg;
	logic [17:0] a0, a1, b0, b1, sa, sb, bk, so_a, so_b, sa_l, sb_l, hold;
	logic [53:0] c, cas_e, e;
	logic [54:0] cas, cas_o;
	logic [35:0] o_dout;
	logic [35:0] q [$];
	int          fails, comparisons, cyc;

	dmac_macro DUT (
		.I_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_CE_GRP(ce_grp),
		.I_RESET_GRP(rst_grp), .I_RST_ASYNC(rst_as), .I_REG_EN(reg_en),
		.I_PREADD_EN(pen), .I_PREADD_W9(w9),
		.I_OPERATION_MODE_CONTROL(opm), .I_PREADD_SUB_SELECT(psub),
		.I_OPERAND_A_SOURCE_SELECT(asel), .I_OPERAND_B_SOURCE_SELECT(operand_b_source_select),
		.I_OPERAND_A_SIGNED(asg), .I_OPERAND_B_SIGNED(bsg),
		.I_VALID(valid), .I_A0(a0), .I_A1(a1), .I_B0(b0), .I_B1(b1),
		.I_C(c), .I_SHIFT_IN_A(sa), .I_SHIFT_IN_B(sb),
		.I_PREADD_BACK_SHIFT_IN(bk), .I_CASCADE_IN(cas),
		.O_SHIFT_OUT_A(so_a), .O_SHIFT_OUT_B(so_b),
		.O_PREADD_BACK_SHIFT_OUT(bso), .O_CASCADE_OUT(cas_o),
		.O_READY(o_ready), .O_VALID(o_valid), .I_READY(rdy), .O_DOUT(o_dout)
	);
	dmac_nbr_model nbr (.i_clk(clk), .i_rstn(rstn), .i_stall(stall),
		.i_block(blk), .o_sa(sa), .o_sb(sb), .o_bk(bk), .o_cas(cas),
		.o_ready(rdy));

	task automatic cmp_dout(input logic [35:0] g, input logic [35:0] x);
		comparisons++;
		if (g !== x) begin
			fails++;
			$display("MISMATCH %0t result %h expected %h", $time, g, x);
		end
	endtask
	task automatic cmp_chain(input logic [54:0] g, input logic [54:0] x);
		comparisons++;
		if (g !== x) begin
			fails++;
			$display("MISMATCH %0t chain %h expected %h", $time, g, x);
		end
	endtask
	task automatic cmp_bit(input logic g, input logic x);
		comparisons++;
		if (g !== x) begin
			fails++;
			$display("MISMATCH %0t flag %b expected %b", $time, g, x);
		end
	endtask
	task automatic tally_and_finish();
		if (q.size() != 0)
			fails++;
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [53:0] sx(input logic [35:0] v, input logic s,
			input int w);
		return (s && v[w-1]) ? (54'(v) | ({54{1'b1}} << w))
			: (54'(v) & ~({54{1'b1}} << w));
	endfunction
	// Result as the fabric expects it from the operands at the taking edge.
	function automatic logic [53:0] f_exp();
		logic [17:0] ma [2];
		logic [17:0] mb [2];
		logic [53:0] m [2];
		logic [53:0] p, t0, x, y, u, v;
		for (int i = 0; i < 2; i++) begin
			ma[i] = asel[i] ? sa : (i ? a1 : a0);
			mb[i] = operand_b_source_select[i] ? bk : (i ? b1 : b0);
			u = sx(ma[i], asg[i], w9 ? 9 : 18);
			v = sx(mb[i], bsg[i], w9 ? 9 : 18);
			if (pen[i])
				u = psub[i] ? u - v : u + v;
			m[i] = u * v;
			// Narrow grouping multiplies the low and high halves apart.
			if (opm[1:0] == 2'h1)
				m[i] = sx(ma[i], asg[i], 9) * sx(mb[i], bsg[i], 9)
					+ sx(ma[i] >> 9, asg[i], 9) * sx(mb[i] >> 9, bsg[i], 9);
		end
		case (opm[1:0])
			2'h2: p = m[0] + (m[1] << 18);
			2'h3: p = ((m[0] + (m[1] << 18)) << 18) + cas[53:0];
			default: p = m[0] + m[1];
		endcase
		t0 = opm[5] ? 54'h0 : p;
		x = sx({a1, a0}, asg[1], 36);
		y = sx({b1, b0}, bsg[1], 36);
		case (opm[3:2])
			2'h0: return t0 + x + (opm[4] ? -y : y);
			2'h1: return t0 + y + (opm[4] ? -c : c);
			2'h2: return x + y + (opm[4] ? -c : c);
			default: return t0 + (opm[4] ? -cas[53:0] : cas[53:0]);
		endcase
	endfunction

	// Noting process: every taken word leaves its expected result.
	always @(posedge clk) begin
		if (rstn && cas_p)
			cmp_chain(cas_o, {cas_e[53], cas_e});
		if (rstn && sh_p) begin
			cmp_chain(55'(so_a), 55'(sa_l));
			cmp_chain(55'(so_b), 55'(sb_l));
			if (bs_p)
				cmp_chain(55'(bso), 55'(bs_l));
		end
		cas_p = 1'b0;
		if (rstn && valid && o_ready === 1'b1 && ce) begin
			e = f_exp();
			q.push_back(e[35:0]);
			cas_p = (reg_en == 4'h0);
			cas_e = e;
		end
		sh_p = rstn && ce && o_ready === 1'b1 && ce_grp[0] && !rst_grp[0];
		sa_l = sa;
		sb_l = sb;
		bs_p = !reg_en[0];
		bs_l = operand_b_source_select[0] ? bk : b0;
	end
	// Watching process: each delivered result is matched in order.
	always @(posedge clk) begin
		if (rstn && o_valid === 1'b1 && rdy === 1'b1 && ce)
			cmp_dout(o_dout, q.size() ? q.pop_front() : 36'hx);
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Holds every word until taken; rce also drops the global enable.
	task automatic send(input int n, input logic [17:0] mk, input logic rce);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			valid = 1'b1;
			{a0, a1} = {18'($urandom) & mk, 18'($urandom) & mk};
			{b0, b1} = {18'($urandom) & mk, 18'($urandom) & mk};
			if (psub != 2'h0)
				{b0, b1} = {a0, a1};
			c = {22'($urandom), 32'($urandom)};
			ce = !rce || $urandom_range(3) != 0;
			while (!(o_ready === 1'b1 && ce)) begin
				@(negedge clk);
				ce = !rce || $urandom_range(3) != 0;
			end
		end
		@(negedge clk);
		valid = 1'b0;
		ce = 1'b1;
	endtask
	// Settings change once the pipeline has emptied or 300 cycles have passed.
	task automatic cfg(input logic [3:0] r, input logic [5:0] m,
			input logic [1:0] pe, input logic [1:0] ps, input logic [1:0] sl);
		for (int k = 0; k < 300 && q.size() != 0; k++)
			@(negedge clk);
		@(negedge clk);
		{reg_en, opm, pen, psub, asel, operand_b_source_select} = {r, m, pe, ps, sl, sl};
		{asg, bsg} = 4'($urandom);
		w9 = m[1:0] != 2'h1 && $urandom_range(1) == 1;
		repeat (2) @(negedge clk);
	endtask

	initial begin
		{rstn, ce, valid, blk, stall, cas_p, sh_p, w9, bs_p} = '0;
		{ce_grp, rst_grp, rst_as, reg_en} = 16'hf000;
		{opm, pen, psub, asel, operand_b_source_select, asg, bsg} = '0;
		{a0, a1, b0, b1, c} = '0;
		void'($urandom(98));
		repeat (20) @(negedge clk);
		cmp_bit(o_ready, 1'b1);
		cmp_bit(o_valid, 1'b0);
		{rstn, ce, stall} = 3'h7;
		for (int k = 0; k < 48; k++) begin
			cfg(4'h0, {1'(k / 24), 1'(k / 12), 2'(k / 3),
				2'(k % 4)}, 2'h0, 2'h0, 2'h0);
			send(4, 18'h3ffff, 1'b1);
		end
		for (int k = 0; k < 12; k++) begin
			cfg(4'h0, 6'h0c, (k < 4) ? 2'h0 : (k < 8) ? 2'(k - 4) : 2'h3,
				(k < 8) ? 2'h0 : 2'(k - 8), (k < 4) ? 2'(k) : 2'h0);
			send(4, (k < 4) ? 18'h3ffff : 18'h0ffff, 1'b0);
		end
		for (int k = 0; k < 3; k++) begin
			cfg((k == 0) ? 4'h1 : (k == 1) ? 4'h6 : 4'hf, 6'h10, 2'h0,
				2'h0, 2'h0);
			send(16, 18'h3ffff, 1'b1);
		end
		// A sink that accepts nothing for 8 cycles must stop intake without losing words.
		cfg(4'h0, 6'h00, 2'h0, 2'h0, 2'h0);
		blk = 1'b1;
		fork
			send(6, 18'h3ffff, 1'b0);
			begin
				repeat (8) @(negedge clk);
				cmp_bit(o_ready, 1'b0);
				blk = 1'b0;
			end
		join
		cfg(4'h0, 6'h00, 2'h0, 2'h0, 2'h0);
		ce_grp = 4'he;
		@(negedge clk);
		hold = so_a;
		repeat (3) @(negedge clk);
		cmp_chain(55'(so_a), 55'(hold));
		rst_grp = 4'h9;
		repeat (2) @(negedge clk);
		cmp_chain(55'(so_a), 55'(hold));
		rst_as = 4'h9;
		@(negedge clk);
		cmp_chain(55'(so_a), 55'h0);
		cmp_chain(cas_o, 55'h0);
		{rst_grp, rst_as, ce_grp} = 12'h00f;
		cfg(4'h0, 6'h00, 2'h0, 2'h0, 2'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
